// File: design/iepd_regs.sv
// input endpoint descriptor register bank with answer fifo
// assumes register port and buffer manager on clk_sys, sync reset
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// answer fifo
// ---------------------------------------------------------------
module iepd_fifo
  import iepd_pkg::*;
#(
  parameter int WIDTH = 29,
  parameter int DEPTH = 8
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } iepd_fifo_type;
  iepd_fifo_type st_q;
  iepd_fifo_type st_d;
  logic [AW:0] fill;

  assign fill = st_q.wp - st_q.rp;
  assign inReady = fill != (AW+1)'(DEPTH);
  assign outValid = st_q.wp != st_q.rp;
  assign outData = st_q.mem[st_q.rp[AW-1:0]];

  always_comb
  begin
    st_d = st_q;
    if (inValid && inReady)
    begin
      st_d.mem[st_q.wp[AW-1:0]] = inData;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (outValid && outReady)
    begin
      st_d.rp = st_q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end
endmodule // iepd_fifo

// ---------------------------------------------------------------
// descriptor register bank
// ---------------------------------------------------------------
module iepd_regs
  import iepd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic inReqValid,
  input wire logic [1:0] inReqEp,
  output logic inReqReady,
  input wire logic ackValid,
  input wire iepd_ack_type ackInfo,
  input wire logic setupSeen,
  output logic ansValid,
  input wire logic ansReady,
  output iepd_ans_type ansData
);
  typedef struct packed {
    logic [NEP-1:0][7:0] cfg;
    logic [NEP-1:0][7:0] pBase;
    logic [NEP-1:0][7:0] pCnt;
    logic [NEP-1:0][7:0] sBase;
    logic [NEP-1:0][7:0] sCnt;
    logic [NEP-1:0][7:0] size;
    logic [7:0] e0InCfg;
    logic [7:0] e0InCnt;
    logic [7:0] e0OutCfg;
    logic [7:0] e0OutCnt;
    logic [7:0] rdata;
  } iepd_state_type;

  localparam iepd_state_type ST_RST = '{
    cfg: {NEP{RST_REG}}, pBase: {NEP{RST_REG}},
    pCnt: {NEP{RST_CNT}}, sBase: {NEP{RST_REG}},
    sCnt: {NEP{RST_CNT}}, size: {NEP{RST_REG}},
    e0InCfg: RST_REG, e0InCnt: RST_CNT,
    e0OutCfg: RST_REG, e0OutCnt: RST_CNT, rdata: RST_REG};

  iepd_state_type st_q;
  iepd_state_type st_d;
  iepd_ans_type pushAns;
  logic pushOk;
  logic epHit;
  logic [1:0] rIdx;
  logic [1:0] qIdx;
  logic [1:0] aIdx;
  logic [7:0] qCfg;
  logic qSel;
  logic qNak;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign epHit = regAddr[15:5] == EPN_WIN[15:5] && regAddr[4:3] != 2'h0;
  assign rIdx = 2'(regAddr[4:3] - 2'h1);
  assign qIdx = 2'(inReqEp - 2'h1);
  assign aIdx = 2'(ackInfo.ep - 2'h1);
  assign pushOk = inReqValid && inReqReady;
  assign regRdData = st_q.rdata;

  // ---------------------------------------------------------------
  // IN request decision
  // ---------------------------------------------------------------
  assign qCfg = st_q.cfg[qIdx];
  assign qSel = qCfg[DOUBLE_BUFFER_ENABLE_BIT] && qCfg[TOG_BIT];
  assign qNak = qSel ? st_q.sCnt[qIdx][NAK_BIT] : st_q.pCnt[qIdx][NAK_BIT];

  always_comb
  begin
    pushAns = '0;
    pushAns.kind = ANS_NAK;
    pushAns.ep = inReqEp;
    if (inReqEp == 2'h0)
    begin
      // disabled endpoint is never served
      if (!st_q.e0InCfg[UBME_BIT])
      begin
        pushAns.kind = ANS_NAK;
      end
      else if (st_q.e0InCfg[STALL_BIT])
      begin
        pushAns.kind = ANS_STALL;
      end
      else if (!st_q.e0InCnt[NAK_BIT])
      begin
        pushAns.kind = ANS_DATA;
        pushAns.addr = EP0_IN_BUF;
        // reserved codes above eight fall back to eight
        pushAns.count = st_q.e0InCnt[3:0] > EP0_MAX_CNT ?
          {3'h0, EP0_MAX_CNT} : {3'h0, st_q.e0InCnt[3:0]};
      end
    end
    else
    begin
      pushAns.bufSel = qSel;
      if (!qCfg[UBME_BIT])
      begin
        pushAns.kind = ANS_NAK;
      end
      else if (qCfg[STALL_BIT])
      begin
        pushAns.kind = ANS_STALL;
      end
      else if (!qNak)
      begin
        pushAns.kind = ANS_DATA;
        if (qSel)
        begin
          pushAns.addr = BUF_WIN | {5'h00, st_q.sBase[qIdx], 3'h0};
          pushAns.count = st_q.sCnt[qIdx][6:0];
        end
        else
        begin
          pushAns.addr = BUF_WIN | {5'h00, st_q.pBase[qIdx], 3'h0};
          pushAns.count = st_q.pCnt[qIdx][6:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    if (regRd)
    begin
      if (regAddr == EP0_IN_CFG)
      begin
        st_d.rdata = st_q.e0InCfg;
      end
      else if (regAddr == EP0_IN_CNT)
      begin
        st_d.rdata = st_q.e0InCnt;
      end
      else if (regAddr == EP0_OUT_CFG)
      begin
        st_d.rdata = st_q.e0OutCfg;
      end
      else if (regAddr == EP0_OUT_CNT)
      begin
        st_d.rdata = st_q.e0OutCnt;
      end
      else if (epHit)
      begin
        case (regAddr[2:0])
          OFS_CFG: st_d.rdata = st_q.cfg[rIdx];
          OFS_PBASE: st_d.rdata = st_q.pBase[rIdx];
          OFS_PCNT: st_d.rdata = st_q.pCnt[rIdx];
          OFS_SBASE: st_d.rdata = st_q.sBase[rIdx];
          OFS_SCNT: st_d.rdata = st_q.sCnt[rIdx];
          OFS_SIZE: st_d.rdata = st_q.size[rIdx];
          default: st_d.rdata = 8'h00;
        endcase
      end
    end
    // stall of endpoints 1-3 is spent by its handshake; a software set in the
    // same cycle wins because the write comes after
    if (pushOk && pushAns.kind == ANS_STALL && inReqEp != 2'h0)
    begin
      st_d.cfg[qIdx][STALL_BIT] = 1'b0;
    end
    if (setupSeen)
    begin
      st_d.e0InCfg[STALL_BIT] = 1'b0;
      st_d.e0OutCfg[STALL_BIT] = 1'b0;
    end
    if (regWr)
    begin
      if (regAddr == EP0_IN_CFG)
      begin
        st_d.e0InCfg = (regWrData & CFG0_WMASK) | (st_q.e0InCfg & ~CFG0_WMASK);
      end
      else if (regAddr == EP0_IN_CNT)
      begin
        st_d.e0InCnt = regWrData & CNT0_WMASK;
      end
      else if (regAddr == EP0_OUT_CFG)
      begin
        st_d.e0OutCfg = (regWrData & CFG0_WMASK) | (st_q.e0OutCfg & ~CFG0_WMASK);
      end
      else if (regAddr == EP0_OUT_CNT)
      begin
        st_d.e0OutCnt = regWrData & CNT0_WMASK;
      end
      else if (epHit)
      begin
        case (regAddr[2:0])
          OFS_CFG: st_d.cfg[rIdx] = regWrData & CFGN_WMASK;
          OFS_PBASE: st_d.pBase[rIdx] = regWrData;
          OFS_PCNT: st_d.pCnt[rIdx] = regWrData;
          OFS_SBASE: st_d.sBase[rIdx] = regWrData;
          OFS_SCNT: st_d.sCnt[rIdx] = regWrData;
          OFS_SIZE: st_d.size[rIdx] = regWrData & SIZE_WMASK;
          default: st_d.rdata = st_d.rdata;
        endcase
      end
    end
    // hardware marking a buffer empty beats a software clear
    if (ackValid)
    begin
      if (ackInfo.ep == 2'h0)
      begin
        st_d.e0InCnt[NAK_BIT] = 1'b1;
        st_d.e0InCfg[TOG_BIT] = ~st_q.e0InCfg[TOG_BIT];
      end
      else
      begin
        if (ackInfo.bufSel)
        begin
          st_d.sCnt[aIdx][NAK_BIT] = 1'b1;
        end
        else
        begin
          st_d.pCnt[aIdx][NAK_BIT] = 1'b1;
        end
        st_d.cfg[aIdx][TOG_BIT] = ~st_q.cfg[aIdx][TOG_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= ST_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // answer path
  // ---------------------------------------------------------------
  // a full fifo stalls requests rather than dropping answers
  iepd_fifo #(
    .WIDTH($bits(iepd_ans_type)),
    .DEPTH(FIFO_DEPTH)
  ) iepd_fifo_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(inReqValid),
    .inReady(inReqReady),
    .inData(pushAns),
    .outValid(ansValid),
    .outReady(ansReady),
    .outData(ansData)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_nak_when_empty: assert property (
    pushOk && inReqEp != 2'h0 && qNak |-> pushAns.kind != ANS_DATA)
    else $error("empty buffer served with data");

  a_data_when_full: assert property (
    pushOk && inReqEp != 2'h0 && !qNak && qCfg[UBME_BIT] && !qCfg[STALL_BIT]
    |-> pushAns.kind == ANS_DATA)
    else $error("full buffer not served");

  a_primary_count: assert property (
    pushOk && pushAns.kind == ANS_DATA && inReqEp != 2'h0 && !qSel
    |-> pushAns.count == st_q.pCnt[qIdx][6:0])
    else $error("primary count mismatch");

  a_secondary_addr: assert property (
    pushOk && pushAns.kind == ANS_DATA && inReqEp != 2'h0 && qSel
    |-> pushAns.addr == {5'h1F, st_q.sBase[qIdx], 3'h0})
    else $error("secondary start address wrong");

  a_base_kept: assert property (
    !regWr ##1 1 |-> st_q.sBase == $past(st_q.sBase))
    else $error("base changed without write");

  a_toggle_select: assert property (
    pushOk && inReqEp != 2'h0 && pushAns.kind == ANS_DATA
    |-> pushAns.bufSel == (qCfg[DOUBLE_BUFFER_ENABLE_BIT] & qCfg[TOG_BIT]))
    else $error("wrong buffer selected");

  a_ack_empties: assert property (
    ackValid && ackInfo.ep == 2'h1 && !ackInfo.bufSel
    |=> st_q.pCnt[0][NAK_BIT] ##1 1)
    else $error("acknowledged buffer not emptied");

  a_size_rsv_zero: assert property (
    regRd && epHit && regAddr[2:0] == OFS_SIZE |=> !regRdData[7])
    else $error("size reserved bit set");

  a_ep0_addr: assert property (
    pushOk && inReqEp == 2'h0 && pushAns.kind == ANS_DATA
    |-> pushAns.addr == 16'hFEF8 && pushAns.count <= 7'h08)
    else $error("endpoint zero answer wrong");

  a_ep0_count_map: assert property (
    regRd && regAddr == 16'hFF81
    |=> regRdData == {$past(st_q.e0InCnt[7]), 3'h0, $past(st_q.e0InCnt[3:0])})
    else $error("endpoint zero count read wrong");

  a_read_once: assert property (
    !regRd |=> regRdData == 8'h00)
    else $error("read data outside its cycle");

  c_data_answer: cover property (pushOk && pushAns.kind == ANS_DATA);
  c_nak_answer: cover property (pushOk && pushAns.kind == ANS_NAK);
  c_fifo_full: cover property (inReqValid && !inReqReady);
  c_secondary: cover property (pushOk && pushAns.bufSel ##[1:8] ackValid);

endmodule // iepd_regs

`default_nettype wire

// File: design/iepd_pkg.sv
// constants, field layout and carrier types of the input endpoint
// descriptor register bank; assumes one 100 MHz clock domain
package iepd_pkg;

  localparam int NEP = 3;
  localparam int FIFO_DEPTH = 8;

  // endpoint zero register addresses
  localparam logic [15:0] EP0_IN_CFG = 16'hFF80;
  localparam logic [15:0] EP0_IN_CNT = 16'hFF81;
  localparam logic [15:0] EP0_OUT_CFG = 16'hFF82;
  localparam logic [15:0] EP0_OUT_CNT = 16'hFF83;
  // endpoint n occupies EPN_WIN + 8*n, n = 1..3
  localparam logic [15:0] EPN_WIN = 16'hFF00;
  localparam logic [2:0] OFS_CFG = 3'h0;
  localparam logic [2:0] OFS_PBASE = 3'h1;
  localparam logic [2:0] OFS_PCNT = 3'h2;
  localparam logic [2:0] OFS_SBASE = 3'h3;
  localparam logic [2:0] OFS_SCNT = 3'h4;
  localparam logic [2:0] OFS_SIZE = 3'h5;

  // field positions; endpoint zero shares all but the double buffer enable bit with endpoints 1-3
  localparam int NAK_BIT = 7;
  localparam int UBME_BIT = 7;
  localparam int TOG_BIT = 5;
  localparam int DOUBLE_BUFFER_ENABLE_BIT = 4;
  localparam int STALL_BIT = 3;

  localparam logic [7:0] CFGN_WMASK = 8'hFC;
  localparam logic [7:0] CFG0_WMASK = 8'h8C;
  localparam logic [7:0] CNT0_WMASK = 8'h8F;
  localparam logic [7:0] SIZE_WMASK = 8'h7F;
  localparam logic [3:0] EP0_MAX_CNT = 4'h8;

  localparam logic [7:0] RST_CNT = 8'h80;
  localparam logic [7:0] RST_REG = 8'h00;

  // buffer memory window and fixed endpoint zero buffers
  localparam logic [15:0] BUF_WIN = 16'hF800;
  localparam logic [15:0] EP0_IN_BUF = 16'hFEF8;
  localparam logic [15:0] EP0_OUT_BUF = 16'hFEF0;

  typedef enum logic [2:0] {
    ANS_DATA = 3'b001,
    ANS_NAK = 3'b010,
    ANS_STALL = 3'b100
  } iepd_kind_type;

  typedef struct packed {
    iepd_kind_type kind;
    logic [1:0] ep;
    logic bufSel;
    logic [15:0] addr;
    logic [6:0] count;
  } iepd_ans_type;

  typedef struct packed {
    logic [1:0] ep;
    logic bufSel;
  } iepd_ack_type;

endpackage

// File: tb/iepd_host_model.sv
// host side model: issues IN requests, takes answers, reports acks
// assumes the register bank's request, answer and ack ports on clk_sys
`timescale 1ns/1ps
`default_nettype none

module iepd_host_model
  import iepd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic hold,
  input wire logic inReqReady,
  input wire logic ansValid,
  input wire iepd_ans_type ansData,
  output logic inReqValid,
  output logic [1:0] inReqEp,
  output logic ansReady,
  output logic ackValid,
  output iepd_ack_type ackInfo
);
  iepd_ans_type got[$];

  initial
  begin
    inReqValid = 1'b0;
    inReqEp = 2'h0;
    ansReady = 1'b0;
    ackValid = 1'b0;
    ackInfo = '0;
  end

  // hold models a slow host that leaves answers queued
  always @(posedge clk_sys)
  begin
    ansReady <= !hold;
    if (ansValid && ansReady)
      got.push_back(ansData);
  end

  task automatic req(input logic [1:0] ep, output bit ok);
    bit rdy;
    ok = 1'b0;
    @(posedge clk_sys);
    inReqValid <= 1'b1;
    inReqEp <= ep;
    for (int i = 0; i < 60 && !ok; i++)
    begin
      @(negedge clk_sys);
      rdy = inReqReady;
      @(posedge clk_sys);
      ok = rdy;
    end
    inReqValid <= 1'b0;
    // a released select must not look like the last request
    inReqEp <= ~ep;
  endtask

  task automatic ack(input logic [1:0] ep, input logic sel);
    @(posedge clk_sys);
    ackValid <= 1'b1;
    ackInfo <= '{ep, sel};
    @(posedge clk_sys);
    ackValid <= 1'b0;
    ackInfo <= '{~ep, ~sel};
  endtask
endmodule // iepd_host_model

`default_nettype wire

// File: tb/iepd_regs_test.sv
// self-checking bench for the descriptor register bank
// assumes iepd_pkg, iepd_regs and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none

module iepd_regs_test
  import iepd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic setupSeen = 1'b0;
  logic hold = 1'b0;
  logic [7:0] regRdData;
  logic inReqValid, inReqReady, ackValid, ansValid, ansReady;
  logic [1:0] inReqEp;
  iepd_ack_type ackInfo;
  iepd_ans_type ansData;
  int n_mismatch = 0;
  int checked = 0;

  always #5 clk_sys = ~clk_sys;

  iepd_regs iepd_regs_inst (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .inReqValid(inReqValid), .inReqEp(inReqEp), .inReqReady(inReqReady),
    .ackValid(ackValid), .ackInfo(ackInfo), .setupSeen(setupSeen),
    .ansValid(ansValid), .ansReady(ansReady), .ansData(ansData));

  iepd_host_model iepd_host_model_inst (.clk_sys(clk_sys), .hold(hold),
    .inReqReady(inReqReady), .ansValid(ansValid), .ansData(ansData),
    .inReqValid(inReqValid), .inReqEp(inReqEp), .ansReady(ansReady),
    .ackValid(ackValid), .ackInfo(ackInfo));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout();
    n_mismatch++;
    print_verdict();
  endtask

  task automatic chk(input logic [28:0] got, input logic [28:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] ra(input int n, input logic [2:0] o);
    return EPN_WIN + 16'(8 * n) + 16'(o);
  endfunction

  function automatic logic [15:0] ba(input logic [7:0] b);
    return BUF_WIN | (16'(b) << 3);
  endfunction

  // values are not limited to 64; two set masked bits so the reads check the size and endpoint zero count write masks
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    chk(29'(regRdData), 29'(exp));
  endtask

  task automatic ans(input iepd_kind_type k, input logic [1:0] ep, input logic sel,
      input logic [15:0] a, input logic [6:0] c);
    iepd_ans_type g;
    for (int i = 0; i < 60 && iepd_host_model_inst.got.size() == 0; i++)
      @(posedge clk_sys);
    if (iepd_host_model_inst.got.size() == 0)
      timeout();
    g = iepd_host_model_inst.got.pop_front();
    chk(29'(g.kind), 29'(k));
    chk(29'(g.ep), 29'(ep));
    // address and count only carry meaning for a data answer
    if (k == ANS_DATA)
      chk(29'({g.bufSel, g.addr, g.count}), 29'({sel, a, c}));
  endtask

  task automatic txn(input logic [1:0] ep, input iepd_kind_type k, input logic sel,
      input logic [15:0] a, input logic [6:0] c);
    bit ok;
    iepd_host_model_inst.req(ep, ok);
    if (!ok)
      timeout();
    ans(k, ep, sel, a, c);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(EP0_IN_CFG, 8'h00);
    rd(EP0_IN_CNT, 8'h80);
    rd(EP0_OUT_CNT, 8'h80);
    rd(EP0_OUT_CFG, 8'h00);
    rd(ra(1, OFS_PCNT), 8'h80);
    rd(ra(2, OFS_SCNT), 8'h80);
    rd(16'hFFF0, 8'h00);
  endtask

  task automatic t_fields();
    wr(ra(3, OFS_SBASE), 8'hA5);
    rd(ra(3, OFS_SBASE), 8'hA5);
    wr(ra(3, OFS_SIZE), 8'hC0);
    rd(ra(3, OFS_SIZE), 8'h40);
    wr(ra(3, OFS_SCNT), 8'h40);
    rd(ra(3, OFS_SCNT), 8'h40);
    wr(ra(3, OFS_PCNT), 8'hBF);
    rd(ra(3, OFS_PCNT), 8'hBF);
    wr(EP0_IN_CNT, 8'h78);
    rd(EP0_IN_CNT, 8'h08);
    wr(EP0_OUT_CNT, 8'h05);
    rd(EP0_OUT_CNT, 8'h05);
  endtask

  task automatic t_double_buffer_enable();
    wr(ra(1, OFS_PBASE), 8'h10);
    wr(ra(1, OFS_PCNT), 8'h05);
    wr(ra(1, OFS_SBASE), 8'h20);
    wr(ra(1, OFS_SCNT), 8'h07);
    wr(ra(1, OFS_CFG), 8'h90);
    txn(2'd1, ANS_DATA, 1'b0, ba(8'h10), 7'd5);
    iepd_host_model_inst.ack(2'd1, 1'b0);
    rd(ra(1, OFS_PCNT), 8'h85);
    rd(ra(1, OFS_PBASE), 8'h10);
    rd(ra(1, OFS_CFG), 8'hB0);
    txn(2'd1, ANS_DATA, 1'b1, ba(8'h20), 7'd7);
    iepd_host_model_inst.ack(2'd1, 1'b1);
    rd(ra(1, OFS_SCNT), 8'h87);
    txn(2'd1, ANS_NAK, 1'b0, 16'h0000, 7'd0);
  endtask

  task automatic t_ep0();
    wr(EP0_IN_CNT, 8'h08);
    wr(EP0_IN_CFG, 8'h80);
    txn(2'd0, ANS_DATA, 1'b0, EP0_IN_BUF, 7'd8);
    iepd_host_model_inst.ack(2'd0, 1'b0);
    rd(EP0_IN_CNT, 8'h88);
    rd(EP0_IN_CFG, 8'hA0);
    wr(EP0_IN_CFG, 8'h88);
    txn(2'd0, ANS_STALL, 1'b0, 16'h0000, 7'd0);
    txn(2'd0, ANS_STALL, 1'b0, 16'h0000, 7'd0);
    @(posedge clk_sys);
    setupSeen <= 1'b1;
    @(posedge clk_sys);
    setupSeen <= 1'b0;
    rd(EP0_IN_CFG, 8'hA0);
    // reserved counts above eight are served as eight
    wr(EP0_IN_CNT, 8'h0F);
    rd(EP0_IN_CNT, 8'h0F);
    txn(2'd0, ANS_DATA, 1'b0, EP0_IN_BUF, 7'd8);
  endtask

  // a stall handshake spends the stall bit of endpoint 3
  task automatic t_stall();
    wr(ra(3, OFS_CFG), 8'h88);
    txn(2'd3, ANS_STALL, 1'b0, 16'h0000, 7'd0);
    rd(ra(3, OFS_CFG), 8'h80);
    txn(2'd3, ANS_NAK, 1'b0, 16'h0000, 7'd0);
    wr(ra(3, OFS_PCNT), 8'h3F);
    txn(2'd3, ANS_DATA, 1'b0, ba(8'h00), 7'd63);
  endtask

  // a slow host lets the answer queue fill to its depth
  task automatic t_full();
    bit ok;
    @(posedge clk_sys);
    hold <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      iepd_host_model_inst.req(2'd2, ok);
      if (!ok)
        timeout();
    end
    @(negedge clk_sys);
    chk(29'(inReqReady), 29'(0));
    @(posedge clk_sys);
    hold <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++)
      ans(ANS_NAK, 2'd2, 1'b0, 16'h0000, 7'd0);
    @(negedge clk_sys);
    chk(29'(ansValid), 29'(0));
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_fields();
    t_double_buffer_enable();
    t_ep0();
    t_stall();
    t_full();
    print_verdict();
  end
endmodule // iepd_regs_test

`default_nettype wire
